// [ptr_move_pkg.sv]
// Constants, encodings and carrier types for the pointer-load and file-move executor
package ptr_move_pkg;

  // Widths
  localparam int INSTR_W   = 16;
  localparam int PTR_W     = 14;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 14;
  localparam int BANK_W    = 6;
  localparam int NUM_PTR   = 3;
  localparam int LIT_HI_W  = 4;
  localparam int LIT_LO_W  = 10;

  // Opcode prefixes
  localparam logic [7:0] PTR_FIRST_PREFIX  = 8'hee;
  localparam logic [1:0] PTR_FIRST_ZEROS   = 2'h0;
  localparam logic [3:0] PTR_SECOND_PREFIX = 4'hf;
  localparam logic [1:0] PTR_SECOND_ZEROS  = 2'h0;
  localparam logic [5:0] MOVE_PREFIX       = 6'h14;

  // Field positions
  localparam int SEL_LSB   = 4;
  localparam int DEST_BIT  = 9;
  localparam int BANK_BIT  = 8;
  localparam int SIGN_BIT  = 7;

  // Addressing constants
  localparam logic [1:0]  PTR_SEL_MAX      = 2'h2;
  localparam logic [7:0]  INDEXED_LIMIT    = 8'h5f;
  localparam logic [5:0]  ACCESS_LOW_BANK  = 6'h00;
  localparam logic [5:0]  ACCESS_HIGH_BANK = 6'h3f;
  localparam int          INDEX_PTR        = 2;

  // Values after reset
  localparam logic [13:0] PTR_RESET  = 14'h0000;
  localparam logic [7:0]  WREG_RESET = 8'h00;
  localparam logic [13:0] ADDR_RESET = 14'h0000;

  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_e;

  // Kind of the instruction cycle in progress
  typedef enum logic [1:0] {
    SEQ_IDLE   = 2'b00,
    SEQ_PTR_HI = 2'b01,
    SEQ_PTR_LO = 2'b10,
    SEQ_MOVE   = 2'b11
  } seq_e;

  // Data memory request
  typedef struct packed {
    logic              rd;
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } file_bus_s;

  // Status flag outputs
  typedef struct packed {
    logic neg;
    logic zero;
    logic upd;
  } status_s;

endpackage

// [ptr_move_exec.sv]
// Decode and execute of the pointer-load and file-move instructions
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - Pointer load takes selector 0 to 2 and a 14-bit literal.
// - The whole 14-bit literal lands in the selected indirect pointer.
// - Pointer load is two words: 11101110 00 sel k13..10, then 1111 00 k9..0.
// - Pointer load never touches the status flags.
// - First cycle reads literal 13..10, writes pointer 13..10 in phase four.
// - Second cycle writes pointer 9..0 in phase four; two cycles total.
// - File move takes 8-bit address, destination bit and bank bit.
// - Destination 0 sends the file value to the working register.
// - Destination 1 writes the value back into the same file register.
// - Bank 0 uses the access bank; bank 1 uses the bank select register.
// - Bank 0, extended set on and address at most 5Fh gives indexed mode.
// - File move sets negative and zero flags from the moved value.
// - File move is one cycle: decode, read, process, write.
module ptr_move_exec #(
  parameter int PTR_W  = 14,                            // Pointer width
  parameter int DATA_W = 8                              // Data width
) (
  input  wire logic                          clk_sys_i,         // Core clock
  input  wire logic                          resetn_i,          // Async reset, low
  input  wire logic [15:0]                   instr_i,           // Instruction word
  input  wire logic                          instr_valid_i,     // Word present
  output logic                               instr_ready_o,     // Word taken in decode
  output ptr_move_pkg::phase_e               phase_o,           // Current phase
  input  wire logic                          ext_set_en_i,      // Extended set on
  input  wire logic [5:0]                    bank_select_reg_i, // Bank select value
  input  wire logic [7:0]                    file_rdata_i,      // File read data
  output ptr_move_pkg::file_bus_s            file_bus_o,        // File request
  output logic [7:0]                         working_reg_o,     // Working register
  output ptr_move_pkg::status_s              flags_o,           // N, Z and update
  output logic [2:0][13:0]                   indirect_pointer_reg_o // Pointers
);

  // Refuse widths the fixed encodings cannot serve, at elaboration
  if (PTR_W != ptr_move_pkg::PTR_W || DATA_W != ptr_move_pkg::DATA_W) begin : g_bad_width
    $error("ptr_move_exec: pointer and data widths are fixed by the encoding");
  end

  // Decode helpers
  function automatic logic is_ptr_first(input logic [15:0] w);
    return w[15:8] == ptr_move_pkg::PTR_FIRST_PREFIX
        && w[7:6] == ptr_move_pkg::PTR_FIRST_ZEROS
        && w[5:4] <= ptr_move_pkg::PTR_SEL_MAX;
  endfunction

  function automatic logic is_ptr_second(input logic [15:0] w);
    return w[15:12] == ptr_move_pkg::PTR_SECOND_PREFIX
        && w[11:10] == ptr_move_pkg::PTR_SECOND_ZEROS;
  endfunction

  function automatic logic is_move(input logic [15:0] w);
    return w[15:10] == ptr_move_pkg::MOVE_PREFIX;
  endfunction

  ptr_move_pkg::phase_e phase;
  ptr_move_pkg::seq_e   seq;
  logic                 taken;
  logic [1:0]           ptr_sel;
  logic [3:0]           lit_hi;
  logic [9:0]           lit_lo;
  logic                 dest;
  logic [13:0]          file_addr;
  logic [7:0]           move_value;
  logic [7:0]           working_reg;
  logic                 flag_neg;
  logic                 flag_zero;
  logic                 flag_upd;
  logic [13:0]          ptr [3];
  logic [13:0]          next_addr;
  logic                 indexed;

  assign taken         = instr_valid_i && (phase == ptr_move_pkg::PH_DECODE);
  assign instr_ready_o = (phase == ptr_move_pkg::PH_DECODE);
  assign phase_o       = phase;

  // Phase counter, free running
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      phase <= ptr_move_pkg::PH_DECODE;
    end else begin
      phase <= ptr_move_pkg::phase_e'(phase + 2'h1);
    end
  end

  // Sequence of instruction cycles
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      seq <= ptr_move_pkg::SEQ_IDLE;
    end else if (phase == ptr_move_pkg::PH_DECODE) begin
      case (seq)
        ptr_move_pkg::SEQ_PTR_HI: begin
          if (taken && is_ptr_second(instr_i)) begin
            seq <= ptr_move_pkg::SEQ_PTR_LO;
          end else begin
            seq <= ptr_move_pkg::SEQ_IDLE;
          end
        end
        default: begin
          if (taken && is_ptr_first(instr_i)) begin
            seq <= ptr_move_pkg::SEQ_PTR_HI;
          end else if (taken && is_move(instr_i)) begin
            seq <= ptr_move_pkg::SEQ_MOVE;
          end else begin
            seq <= ptr_move_pkg::SEQ_IDLE;
          end
        end
      endcase
    end
  end

  // Operand latches taken in decode
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      ptr_sel <= 2'h0;
      lit_hi  <= 4'h0;
      lit_lo  <= 10'h000;
      dest    <= 1'b0;
    end else if (taken) begin
      if (seq == ptr_move_pkg::SEQ_PTR_HI) begin
        lit_lo <= instr_i[9:0];
      end else if (is_ptr_first(instr_i)) begin
        ptr_sel <= instr_i[ptr_move_pkg::SEL_LSB +: 2];
        lit_hi  <= instr_i[3:0];
      end else begin
        dest <= instr_i[ptr_move_pkg::DEST_BIT];
      end
    end
  end

  // Address selection for a move
  always_comb begin
    indexed = !instr_i[ptr_move_pkg::BANK_BIT] && ext_set_en_i
           && (instr_i[7:0] <= ptr_move_pkg::INDEXED_LIMIT);
    if (instr_i[ptr_move_pkg::BANK_BIT]) begin
      next_addr = {bank_select_reg_i, instr_i[7:0]};
    end else if (indexed) begin
      next_addr = 14'(ptr[ptr_move_pkg::INDEX_PTR] + {6'h00, instr_i[7:0]});
    end else if (instr_i[7:0] <= ptr_move_pkg::INDEXED_LIMIT) begin
      next_addr = {ptr_move_pkg::ACCESS_LOW_BANK, instr_i[7:0]};
    end else begin
      next_addr = {ptr_move_pkg::ACCESS_HIGH_BANK, instr_i[7:0]};
    end
  end

  // File address register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      file_addr <= ptr_move_pkg::ADDR_RESET;
    end else if (taken && seq != ptr_move_pkg::SEQ_PTR_HI && is_move(instr_i)) begin
      file_addr <= next_addr;
    end
  end

  // Move data captured at the end of process
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      move_value <= 8'h00;
    end else if (seq == ptr_move_pkg::SEQ_MOVE && phase == ptr_move_pkg::PH_PROCESS) begin
      move_value <= file_rdata_i;
    end
  end

  // File bus, strobes tied to phases
  assign file_bus_o.rd    = (seq == ptr_move_pkg::SEQ_MOVE)
                         && (phase == ptr_move_pkg::PH_READ);
  assign file_bus_o.wr    = (seq == ptr_move_pkg::SEQ_MOVE)
                         && (phase == ptr_move_pkg::PH_WRITE) && dest;
  assign file_bus_o.addr  = file_addr;
  assign file_bus_o.wdata = move_value;

  // Working register
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      working_reg <= ptr_move_pkg::WREG_RESET;
    end else if (seq == ptr_move_pkg::SEQ_MOVE && phase == ptr_move_pkg::PH_WRITE
                 && !dest) begin
      working_reg <= move_value;
    end
  end
  assign working_reg_o = working_reg;

  // Status flags, moves only
  // pointer loads skip flags
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flag_neg  <= 1'b0;
      flag_zero <= 1'b0;
      flag_upd  <= 1'b0;
    end else begin
      flag_upd <= 1'b0;
      if (seq == ptr_move_pkg::SEQ_MOVE && phase == ptr_move_pkg::PH_WRITE) begin
        flag_neg  <= move_value[ptr_move_pkg::SIGN_BIT];
        flag_zero <= (move_value == 8'h00);
        flag_upd  <= 1'b1;
      end
    end
  end
  assign flags_o.neg  = flag_neg;
  assign flags_o.zero = flag_zero;
  assign flags_o.upd  = flag_upd;

  // Pointer registers, one per selector
  // selected pointer loaded in two parts, bits 13..10 then bits 9..0
  for (genvar g = 0; g < ptr_move_pkg::NUM_PTR; g++) begin : g_ptr
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
      if (!resetn_i) begin
        ptr[g] <= ptr_move_pkg::PTR_RESET;
      end else if (phase == ptr_move_pkg::PH_WRITE && ptr_sel == 2'(g)) begin
        if (seq == ptr_move_pkg::SEQ_PTR_HI) begin
          ptr[g][13:10] <= lit_hi;
        end else if (seq == ptr_move_pkg::SEQ_PTR_LO) begin
          ptr[g][9:0] <= lit_lo;
        end
      end
    end
    assign indirect_pointer_reg_o[g] = ptr[g];
  end

  // Checks on the executed behaviour
  logic [13:0] expect_ptr;
  assign expect_ptr = {lit_hi, lit_lo};

  a_ptr_full_load: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (seq == ptr_move_pkg::SEQ_PTR_LO && phase == ptr_move_pkg::PH_WRITE)
    |=> ptr[ptr_sel] == $past(expect_ptr))
    else $error("pointer does not hold the full literal");

  a_ptr_hi_phase: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (seq == ptr_move_pkg::SEQ_PTR_HI && phase != ptr_move_pkg::PH_WRITE)
    |=> $stable(ptr[ptr_sel]))
    else $error("pointer changed before phase four");

  a_ptr_two_cycles: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (seq == ptr_move_pkg::SEQ_PTR_LO && phase == ptr_move_pkg::PH_DECODE)
    |-> $past(seq, 4) == ptr_move_pkg::SEQ_PTR_HI)
    else $error("second pointer cycle without a first");

  a_ptr_no_flags: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (seq == ptr_move_pkg::SEQ_PTR_HI || seq == ptr_move_pkg::SEQ_PTR_LO)
    |=> !flag_upd && $stable(flag_neg) && $stable(flag_zero))
    else $error("pointer load altered a status flag");

  a_move_to_work: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (seq == ptr_move_pkg::SEQ_MOVE && phase == ptr_move_pkg::PH_PROCESS && !dest)
    ##1 1'b1 |=> working_reg == $past(file_rdata_i, 2))
    else $error("working register missed the moved value");

  a_move_writeback: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    file_bus_o.wr |-> dest && file_bus_o.wdata == $past(file_rdata_i)
      && $past(file_bus_o.rd, 2) && file_bus_o.addr == $past(file_bus_o.addr, 2))
    else $error("write back not to the register just read");

  a_bank_addr: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (taken && seq != ptr_move_pkg::SEQ_PTR_HI && is_move(instr_i)
     && instr_i[ptr_move_pkg::BANK_BIT])
    |=> file_addr == {$past(bank_select_reg_i), $past(instr_i[7:0])})
    else $error("banked address wrong");

  a_indexed_addr: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    (taken && seq != ptr_move_pkg::SEQ_PTR_HI && is_move(instr_i) && indexed)
    |=> file_addr == 14'($past(ptr[ptr_move_pkg::INDEX_PTR]) + {6'h00, $past(instr_i[7:0])}))
    else $error("indexed address wrong");

  a_move_flags: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    flag_upd |-> flag_zero == ($past(move_value) == 8'h00)
      && flag_neg == $past(move_value[7]))
    else $error("flags do not follow the moved value");

  a_move_one_cycle: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    file_bus_o.rd |-> ##2 (phase == ptr_move_pkg::PH_WRITE && seq == ptr_move_pkg::SEQ_MOVE))
    else $error("move did not finish in one instruction cycle");

  a_ptr_sel_range: assert property (
    @(posedge clk_sys_i) disable iff (!resetn_i)
    seq == ptr_move_pkg::SEQ_PTR_HI |-> ptr_sel <= ptr_move_pkg::PTR_SEL_MAX)
    else $error("pointer selector out of range");

endmodule

`default_nettype wire

// [file_memory_model.sv]
// Data memory model answering the executor's file read and write requests
`timescale 1ns/1ns
`default_nettype none
module file_memory_model (
  input  wire logic                    clk_sys_i,    // Core clock
  input  wire logic                    resetn_i,     // Async reset, low
  input  wire ptr_move_pkg::file_bus_s file_bus_i,   // Request from executor
  output logic [7:0]                   file_rdata_o, // Read data
  output logic [13:0]                  rd_addr_o,    // Last read address
  output logic [7:0]                   wr_count_o,   // Writes seen
  output logic [13:0]                  wr_addr_o,    // Last write address
  output logic [7:0]                   wr_data_o     // Last write data
);
  logic [7:0] mem [0:16383];
  // Pattern tied to the address, read data starts scrambled
  initial begin
    file_rdata_o = 8'h5a;
    for (int a = 0; a < 16384; a++) begin
      mem[a] = a[7:0] ^ {a[13:8], 2'b00};
    end
  end
  // Data valid for the process phase only, toggling otherwise
  always @(posedge clk_sys_i) begin
    if (file_bus_i.rd) begin
      file_rdata_o <= mem[file_bus_i.addr];
    end else begin
      file_rdata_o <= ~file_rdata_o;
    end
  end
  // Store writes and keep a record of requests
  always @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rd_addr_o  <= 14'h0000;
      wr_count_o <= 8'h00;
      wr_addr_o  <= 14'h0000;
      wr_data_o  <= 8'h00;
    end else begin
      if (file_bus_i.rd) begin
        rd_addr_o <= file_bus_i.addr;
      end
      if (file_bus_i.wr) begin
        mem[file_bus_i.addr] <= file_bus_i.wdata;
        wr_count_o           <= wr_count_o + 8'h01;
        wr_addr_o            <= file_bus_i.addr;
        wr_data_o            <= file_bus_i.wdata;
      end
    end
  end
endmodule
`default_nettype wire

// [tb_pointer_load_and_file_move_exec.sv]
// Self-checking bench for the pointer-load and file-move executor
`timescale 1ns/1ns
`default_nettype none
module tb_pointer_load_and_file_move_exec;
  typedef struct packed {
    logic [15:0] w1;
    logic [15:0] w2;
    logic [5:0]  bank;
    logic        ext;
    logic [13:0] ea;
    logic [7:0]  v;
  } row_s;
  logic                    clk_sys_i = 1'b0;
  logic                    resetn_i = 1'b0;
  logic [15:0]             instr_i = 16'h0000;
  logic                    instr_valid_i = 1'b0;
  logic                    ext_set_en_i = 1'b0;
  logic [5:0]              bank_select_reg_i = 6'h00;
  logic                    instr_ready_o;
  ptr_move_pkg::phase_e    phase_o;
  logic [7:0]              file_rdata;
  ptr_move_pkg::file_bus_s file_bus;
  logic [7:0]              working;
  ptr_move_pkg::status_s   flags;
  logic [2:0][13:0]        ptrs;
  logic [13:0]             rd_addr;
  logic [13:0]             wr_addr;
  logic [7:0]              wr_count;
  logic [7:0]              wr_data;
  int                      fail_count = 0;
  int                      total_checks = 0;
  logic [13:0]             exp_ptr [3];
  logic [7:0]              exp_w;
  logic                    exp_n;
  logic                    exp_z;

  // Core clock
  always #2 clk_sys_i = ~clk_sys_i;

  ptr_move_exec DUT (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .instr_i(instr_i),
    .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .phase_o(phase_o),
    .ext_set_en_i(ext_set_en_i), .bank_select_reg_i(bank_select_reg_i),
    .file_rdata_i(file_rdata), .file_bus_o(file_bus), .working_reg_o(working),
    .flags_o(flags), .indirect_pointer_reg_o(ptrs)
  );
  file_memory_model mem_model (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .file_bus_i(file_bus),
    .file_rdata_o(file_rdata), .rd_addr_o(rd_addr), .wr_count_o(wr_count),
    .wr_addr_o(wr_addr), .wr_data_o(wr_data)
  );

  // Compare one value
  task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task conclude;
    $display("Checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Offer a word for the next decode phase, return after its take edge
  task offer(input logic [15:0] w, input logic [5:0] bank, input logic ext);
    int n;
    n = 0;
    @(posedge clk_sys_i);
    while (phase_o !== ptr_move_pkg::PH_WRITE && n < 8) begin
      @(posedge clk_sys_i);
      n++;
    end
    if (n == 8) begin
      fail_count++;
      conclude();
    end else begin
      instr_i           <= w;
      instr_valid_i     <= 1'b1;
      bank_select_reg_i <= bank;
      ext_set_en_i      <= ext;
      @(posedge clk_sys_i);
      check("ready", {15'h0000, instr_ready_o}, 16'h0001);
      instr_valid_i <= 1'b0;
    end
  endtask

  // Let the instruction cycle finish
  task settle;
    repeat (3) @(posedge clk_sys_i);
    #1;
  endtask

  // Architectural state against the model
  task check_state;
    for (int k = 0; k < 3; k++) begin
      check("pointer", {2'b00, ptrs[k]}, {2'b00, exp_ptr[k]});
    end
    check("working", {8'h00, working}, {8'h00, exp_w});
    check("neg", {15'h0000, flags.neg}, {15'h0000, exp_n});
    check("zero", {15'h0000, flags.zero}, {15'h0000, exp_z});
  endtask

  // Main sequence
  initial begin
    row_s        r;
    logic [13:0] ea;
    logic [7:0]  v;
    logic [7:0]  cnt;
    row_s        rows [9];
    // Words, bank, ext, then address or pointer and the value moved
    rows = '{'{16'h5000, 16'h0000, 6'h00, 1'b0, 14'h0000, 8'h00},
             '{16'h5190, 16'h0000, 6'h02, 1'b0, 14'h0290, 8'h98},
             '{16'hee0f, 16'hf3ff, 6'h00, 1'b0, 14'h3fff, 8'h00},
             '{16'hee10, 16'hf3ab, 6'h00, 1'b0, 14'h03ab, 8'h00},
             '{16'hee2f, 16'hf3c0, 6'h00, 1'b0, 14'h3fc0, 8'h00},
             '{16'h5285, 16'h0000, 6'h00, 1'b0, 14'h3f85, 8'h79},
             '{16'h53ff, 16'h0000, 6'h3f, 1'b0, 14'h3fff, 8'h03},
             '{16'h505f, 16'h0000, 6'h00, 1'b1, 14'h001f, 8'h1f},
             '{16'h5060, 16'h0000, 6'h00, 1'b1, 14'h3f60, 8'h9c}};
    exp_ptr = '{14'h0000, 14'h0000, 14'h0000};
    exp_w = 8'h00;
    exp_n = 1'b0;
    exp_z = 1'b0;
    @(posedge clk_sys_i);
    #1;
    check_state();
    check("ready_rst", {15'h0000, instr_ready_o}, 16'h0001);
    check("phase_rst", {14'h0000, phase_o}, 16'h0000);
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    $display("Test reset done");
    for (int i = 0; i < 9; i++) begin
      r = rows[i];
      cnt = wr_count;
      if (r.w1[15:8] == 8'hee) begin
        offer(r.w1, r.bank, r.ext);
        offer(r.w2, r.bank, r.ext);
        // First cycle upper bits only
        check("ptr_hi", {2'b00, ptrs[r.w1[5:4]]}, {2'b00, r.w1[3:0], exp_ptr[r.w1[5:4]][9:0]});
        settle();
        exp_ptr[r.w1[5:4]] = r.ea;
        check("upd", {15'h0000, flags.upd}, 16'h0000);
      end else begin
        ea = r.ea;
        v = r.v;
        offer(r.w1, r.bank, r.ext);
        settle();
        check("rd_addr", {2'b00, rd_addr}, {2'b00, ea});
        if (r.w1[9]) begin
          check("wr_count", {8'h00, wr_count}, {8'h00, cnt + 8'h01});
          check("wr_addr", {2'b00, wr_addr}, {2'b00, ea});
          check("wr_data", {8'h00, wr_data}, {8'h00, v});
        end else begin
          check("no_wr", {8'h00, wr_count}, {8'h00, cnt});
          exp_w = v;
        end
        exp_n = v[7];
        exp_z = (v == 8'h00);
        check("upd", {15'h0000, flags.upd}, 16'h0001);
      end
      check_state();
      $display("Test %0d done", i);
    end
    // Load abandoned by a move word, which is dropped
    cnt = wr_count;
    offer(16'hee15, 6'h00, 1'b0);
    offer(16'h5200, 6'h00, 1'b0);
    settle();
    exp_ptr[1][13:10] = 4'h5;
    check("abandon_wr", {8'h00, wr_count}, {8'h00, cnt});
    check_state();
    $display("Test abandon done");
    // Selector 3 is not a pointer
    offer(16'hee3f, 6'h00, 1'b0);
    offer(16'hf000, 6'h00, 1'b0);
    settle();
    check_state();
    $display("Test selector done");
    // Reset in mid-run clears state
    @(posedge clk_sys_i);
    resetn_i <= 1'b0;
    repeat (2) @(posedge clk_sys_i);
    #1;
    exp_ptr = '{14'h0000, 14'h0000, 14'h0000};
    exp_w = 8'h00;
    exp_n = 1'b0;
    exp_z = 1'b0;
    check_state();
    $display("Test mid reset done");
    // Release and run one move to show recovery
    @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    offer(16'h5190, 6'h02, 1'b0);
    settle();
    exp_w = 8'h98;
    exp_n = 1'b1;
    check("rd_addr_rst", {2'b00, rd_addr}, 16'h0290);
    check("upd_rst", {15'h0000, flags.upd}, 16'h0001);
    check_state();
    $display("Test after reset done");
    conclude();
  end
endmodule
`default_nettype wire
